// ==== src/flash_self_program_pkg.sv ====
// constants, types and register map of the flash self-programming control unit
// assumes one 25 MHz system clock shared with the processor core and the flash array
`default_nettype none

package flash_self_program_pkg;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int PROG_TIME_MIN_NS = 3700000;
   localparam int PROG_TIME_MAX_NS = 4500000;
   localparam int PROG_CYCLES_MIN = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CYCLES_MAX = PROG_TIME_MAX_NS / CLK_PERIOD_NS;
   localparam int PROG_CNT_W = 17;
   localparam int SPM_WINDOW = 4;
   localparam int LPM_WINDOW = 3;
   localparam int WIN_CNT_W = 3;

   // ==========================================================
   // flash addressing
   localparam int PAGE_WORD_BITS = 5;
   localparam int PAGE_WORDS = 1 << PAGE_WORD_BITS;
   localparam int PAGE_BITS = 16 - 1 - PAGE_WORD_BITS;
   localparam logic [15:0] BUF_ERASED = 16'hFFFF;

   // ==========================================================
   // register map
   localparam logic [7:0] PMCS_INDEX = 8'h37;
   localparam logic [31:0] PMCS_ADDR = {22'h000000, PMCS_INDEX, 2'h0};
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam int BIT_ENABLE = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_WRITE = 2;
   localparam int BIT_RFL = 3;
   localparam int BIT_CLEAR_PAGE_BUFFER_BIT = 4;
   localparam logic [4:0] CMD_STORE = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_RFL = 5'h09;
   localparam logic [4:0] CMD_CLEAR_PAGE_BUFFER_BIT = 5'h11;

   // ==========================================================
   // fuse and lock read selection by pointer bits 1:0
   localparam logic [1:0] PTR_FUSE_LOW = 2'h0;
   localparam logic [1:0] PTR_LOCK = 2'h1;
   localparam logic [1:0] PTR_FUSE_HIGH = 2'h3;
   localparam logic [7:0] NV_UNUSED = 8'hFF;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0,
      MODE_STORE = 3'h1,
      MODE_ERASE = 3'h2,
      MODE_WRITE = 3'h3,
      MODE_RFL = 3'h4,
      MODE_BUSY_ERASE = 3'h5,
      MODE_BUSY_WRITE = 3'h6
   } mode_t;

   typedef struct packed {
      logic store_program_instruction;
      logic load_program_byte_instruction;
      logic [15:0] ptr;
      logic [15:0] data_pair;
   } core_req_t;

   typedef struct packed {
      logic stall;
      logic load_valid;
      logic [7:0] load_data;
   } core_rsp_t;

   typedef struct packed {
      logic [7:0] fuse_low_programmed;
      logic [7:0] fuse_high_programmed;
      logic [1:0] lock_programmed;
   } nv_bits_t;

   typedef struct packed {
      logic [15:0] rd_word;
      logic [PAGE_WORD_BITS-1:0] buf_index;
   } flash_rsp_t;

   typedef struct packed {
      logic erase;
      logic write;
      logic [PAGE_BITS-1:0] page;
      logic [14:0] rd_word_addr;
      logic [15:0] buf_word;
   } flash_cmd_t;

endpackage

`default_nettype wire

// ==== src/cycle_countdown.sv ====
// loadable down counter with an expiry flag
// assumes clear and load come from logic on the same clock
`default_nettype none

module cycle_countdown #(
   parameter int W = 3
) (
   // clock, enable and clear
   input wire logic clk,
   input wire logic ce,
   input wire logic clear,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_value,
   // state
   output logic [W-1:0] remaining,
   output logic expiring
);

   // ==========================================================
   // counter
   always_ff @(posedge clk) begin
      if (clear) begin
         remaining <= '0;
      end else if (ce) begin
         if (load) begin
            remaining <= load_value;
         end else if (remaining != '0) begin
            remaining <= remaining - W'(1);
         end
      end
   end

   assign expiring = (remaining == W'(1));

endmodule

`default_nettype wire

// ==== src/wb_reg_port.sv ====
// classic wishbone slave for the program-memory control register
// assumes a single-cycle classic master; unmapped reads return zero
`default_nettype none

module wb_reg_port
   import flash_self_program_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // register side
   input wire logic [7:0] ctrl_rd_value,
   output logic ctrl_wr_en,
   output logic [7:0] ctrl_wr_value
);

   logic req;
   logic ctrl_hit;

   assign req = wb_cyc_i && wb_stb_i;
   assign ctrl_hit = (wb_adr_i == PMCS_ADDR);

   // ==========================================================
   // answer one cycle after the request, drop ack the cycle after
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= req && !wb_ack_o;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (ce && req && !wb_ack_o) begin
         wb_dat_o <= (ctrl_hit && !wb_we_i) ? {24'h000000, ctrl_rd_value} : 32'h00000000;
      end
   end

   // write lands on the edge where the master samples ack
   assign ctrl_wr_en = ce && req && wb_ack_o && wb_we_i && wb_sel_i[0] && ctrl_hit;
   assign ctrl_wr_value = wb_dat_i[7:0];

endmodule

`default_nettype wire

// ==== src/flash_self_program_control.sv ====
// flash self-programming control: command register, page buffer, fuse/lock reads
// assumes core, eeprom flag, fuse bits and flash array share this clock
`default_nettype none

module flash_self_program_control
   import flash_self_program_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
   // clock, enable and resets
   input wire logic clk,
   input wire logic ce,
   input wire logic reset_n,
   input wire logic brownout_reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // processor core
   input wire core_req_t core_req,
   output core_rsp_t core_rsp,
   // eeprom and non-volatile bits
   input wire logic eeprom_write_active_flag,
   input wire nv_bits_t nv_bits,
   // flash array
   input wire flash_rsp_t flash_rsp,
   output flash_cmd_t flash_cmd
);

   localparam logic [WIN_CNT_W-1:0] RFL_LAST = WIN_CNT_W'(SPM_WINDOW - LPM_WINDOW + 1);

   mode_t mode_q;
   mode_t mode_d;
   logic [WIN_CNT_W-1:0] win_rem;
   logic win_expiring;
   logic [PROG_CNT_W-1:0] op_rem;
   logic op_expiring;
   logic ctrl_wr_en;
   logic [7:0] ctrl_wr_value;
   logic [4:0] cmd;
   logic cmd_valid;
   logic cmd_taken;
   logic clear_page_buffer_bit_taken;
   logic spm_ok;
   logic fuse_hit;
   logic store_hit;
   logic op_start;
   logic soft_clear;
   logic [PAGE_WORD_BITS-1:0] word_index;
   logic [PAGE_BITS-1:0] page_index;
   logic [15:0] buf_mem [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] buf_valid_q;
   logic lpm_p1_q;
   logic fuse_sel_q;
   logic [1:0] ptr_lo_q;

   function automatic logic is_busy(input mode_t m);
      is_busy = (m == MODE_BUSY_ERASE) || (m == MODE_BUSY_WRITE);
   endfunction

   function automatic logic [4:0] ctrl_bits(input mode_t m);
      case (m)
         MODE_STORE: ctrl_bits = CMD_STORE;
         MODE_ERASE, MODE_BUSY_ERASE: ctrl_bits = CMD_ERASE;
         MODE_WRITE, MODE_BUSY_WRITE: ctrl_bits = CMD_WRITE;
         MODE_RFL: ctrl_bits = CMD_RFL;
         default: ctrl_bits = CTRL_RESET;
      endcase
   endfunction

   function automatic logic [7:0] nv_byte(input logic [1:0] sel, input nv_bits_t nv);
      case (sel)
         PTR_FUSE_LOW: nv_byte = ~nv.fuse_low_programmed;
         PTR_LOCK: nv_byte = {NV_UNUSED[7:2], ~nv.lock_programmed};
         PTR_FUSE_HIGH: nv_byte = ~nv.fuse_high_programmed;
         default: nv_byte = NV_UNUSED;
      endcase
   endfunction

   // ==========================================================
   // register port
   wb_reg_port u_wb (
      .clk(clk),
      .ce(ce),
      .reset_n(reset_n && brownout_reset_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .ctrl_rd_value({3'h0, ctrl_bits(mode_q)}),
      .ctrl_wr_en(ctrl_wr_en),
      .ctrl_wr_value(ctrl_wr_value)
   );

   // ==========================================================
   // command decode
   assign cmd = ctrl_wr_value[4:0];
   assign cmd_valid = (cmd == CMD_STORE) || (cmd == CMD_ERASE) || (cmd == CMD_WRITE)
      || (cmd == CMD_RFL);
   // arming is refused while the eeprom is being written or an operation runs
   assign cmd_taken = ctrl_wr_en && !eeprom_write_active_flag && (mode_q == MODE_IDLE)
      && cmd_valid;
   assign clear_page_buffer_bit_taken = ctrl_wr_en && !eeprom_write_active_flag && (mode_q == MODE_IDLE)
      && (cmd == CMD_CLEAR_PAGE_BUFFER_BIT);
   assign spm_ok = core_req.store_program_instruction && !eeprom_write_active_flag;
   assign fuse_hit = (mode_q == MODE_RFL) && core_req.load_program_byte_instruction
      && !eeprom_write_active_flag;
   assign store_hit = (mode_q == MODE_STORE) && spm_ok;
   assign op_start = ((mode_q == MODE_ERASE) || (mode_q == MODE_WRITE)) && spm_ok;
   assign word_index = core_req.ptr[PAGE_WORD_BITS:1];
   assign page_index = core_req.ptr[15:PAGE_WORD_BITS+1];
   // system reset spares a running operation; brownout does not
   assign soft_clear = !brownout_reset_n || (!reset_n && !is_busy(mode_q));

   // ==========================================================
   // command window and operation timer
   cycle_countdown #(.W(WIN_CNT_W)) u_window (
      .clk(clk),
      .ce(ce),
      .clear(soft_clear),
      .load(cmd_taken),
      .load_value(WIN_CNT_W'(SPM_WINDOW)),
      .remaining(win_rem),
      .expiring(win_expiring)
   );

   // length picked at the short end so a slow oscillator still meets the window
   cycle_countdown #(.W(PROG_CNT_W)) u_op_timer (
      .clk(clk),
      .ce(ce),
      .clear(!brownout_reset_n),
      .load(op_start),
      .load_value(PROG_CNT_W'(PROG_CYCLES)),
      .remaining(op_rem),
      .expiring(op_expiring)
   );

   // ==========================================================
   // mode sequencer
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_IDLE: begin
            if (cmd_taken) begin
               case (cmd)
                  CMD_STORE: mode_d = MODE_STORE;
                  CMD_ERASE: mode_d = MODE_ERASE;
                  CMD_WRITE: mode_d = MODE_WRITE;
                  default: mode_d = MODE_RFL;
               endcase
            end
         end
         MODE_STORE: begin
            if (spm_ok || win_expiring) begin
               mode_d = MODE_IDLE;
            end
         end
         MODE_ERASE: begin
            if (spm_ok) begin
               mode_d = MODE_BUSY_ERASE;
            end else if (win_expiring) begin
               mode_d = MODE_IDLE;
            end
         end
         MODE_WRITE: begin
            if (spm_ok) begin
               mode_d = MODE_BUSY_WRITE;
            end else if (win_expiring) begin
               mode_d = MODE_IDLE;
            end
         end
         MODE_RFL: begin
            if (core_req.load_program_byte_instruction || spm_ok || (win_rem == RFL_LAST)) begin
               mode_d = MODE_IDLE;
            end
         end
         MODE_BUSY_ERASE, MODE_BUSY_WRITE: begin
            if (op_expiring) begin
               mode_d = MODE_IDLE;
            end
         end
         default: mode_d = MODE_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (soft_clear) begin
         mode_q <= MODE_IDLE;
      end else if (ce) begin
         mode_q <= mode_d;
      end
   end

   // ==========================================================
   // core halt and flash array commands
   always_ff @(posedge clk) begin
      if (soft_clear) begin
         core_rsp.stall <= 1'b0;
         flash_cmd.erase <= 1'b0;
         flash_cmd.write <= 1'b0;
      end else if (ce) begin
         core_rsp.stall <= is_busy(mode_d);
         flash_cmd.erase <= (mode_d == MODE_BUSY_ERASE);
         flash_cmd.write <= (mode_d == MODE_BUSY_WRITE);
      end
   end

   always_ff @(posedge clk) begin
      if (!brownout_reset_n) begin
         flash_cmd.page <= '0;
      end else if (ce && op_start) begin
         flash_cmd.page <= page_index;
      end
   end

   // ==========================================================
   // temporary page buffer
   always_ff @(posedge clk) begin
      if (!brownout_reset_n || (!reset_n && mode_q != MODE_BUSY_WRITE)) begin
         buf_valid_q <= '0;
      end else if (ce) begin
         if (clear_page_buffer_bit_taken) begin
            buf_valid_q <= '0;
         end else if (eeprom_write_active_flag) begin
            buf_valid_q <= '0;
         end else if ((mode_q == MODE_BUSY_WRITE) && op_expiring) begin
            buf_valid_q <= '0;
         end else if (store_hit) begin
            buf_valid_q[word_index] <= 1'b1;
         end
      end
   end

   // data pair is ignored for erase and write
   always_ff @(posedge clk) begin
      if (ce && store_hit) begin
         buf_mem[word_index] <= core_req.data_pair;
      end
   end

   always_ff @(posedge clk) begin
      if (!brownout_reset_n) begin
         flash_cmd.buf_word <= BUF_ERASED;
      end else if (ce) begin
         flash_cmd.buf_word <= buf_valid_q[flash_rsp.buf_index] ?
            buf_mem[flash_rsp.buf_index] : BUF_ERASED;
      end
   end

   // ==========================================================
   // byte loads: flash bytes or fuse and lock bytes, two cycles after the load
   always_ff @(posedge clk) begin
      if (!reset_n || !brownout_reset_n) begin
         lpm_p1_q <= 1'b0;
         fuse_sel_q <= 1'b0;
         ptr_lo_q <= 2'h0;
         flash_cmd.rd_word_addr <= '0;
      end else if (ce) begin
         lpm_p1_q <= core_req.load_program_byte_instruction;
         if (core_req.load_program_byte_instruction) begin
            fuse_sel_q <= fuse_hit;
            ptr_lo_q <= core_req.ptr[1:0];
            flash_cmd.rd_word_addr <= core_req.ptr[15:1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !brownout_reset_n) begin
         core_rsp.load_valid <= 1'b0;
         core_rsp.load_data <= 8'h00;
      end else if (ce) begin
         core_rsp.load_valid <= lpm_p1_q;
         if (lpm_p1_q) begin
            if (fuse_sel_q) begin
               core_rsp.load_data <= nv_byte(ptr_lo_q, nv_bits);
            end else if (ptr_lo_q[0]) begin
               core_rsp.load_data <= flash_rsp.rd_word[15:8];
            end else begin
               core_rsp.load_data <= flash_rsp.rd_word[7:0];
            end
         end
      end
   end

   // ==========================================================
   // checks
   property p_reserved_zero;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      wb_ack_o |-> (wb_dat_o[7:5] == 3'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_store_timeout;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      (mode_q == MODE_STORE) && win_expiring && !spm_ok |=> (mode_q == MODE_IDLE);
   endproperty
   a_store_timeout: assert property (p_store_timeout) else $error("enable outlived window");

   property p_rfl_timeout;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      $rose(mode_q == MODE_RFL) |-> ##[0:2] (mode_q == MODE_RFL) ##1 (mode_q == MODE_IDLE);
   endproperty
   a_rfl_timeout: assert property (p_rfl_timeout) else $error("read mode outlived window");

   property p_fuse_latency;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      fuse_hit && (core_req.ptr[1:0] == PTR_LOCK) |-> ##2 core_rsp.load_valid
         && (core_rsp.load_data[1:0] == ~$past(nv_bits.lock_programmed, 2));
   endproperty
   a_fuse_latency: assert property (p_fuse_latency) else $error("lock read wrong");

   property p_fuse_high;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      fuse_hit && (core_req.ptr[1:0] == PTR_FUSE_HIGH) |-> ##2
         (core_rsp.load_data == ~$past(nv_bits.fuse_high_programmed, 2));
   endproperty
   a_fuse_high: assert property (p_fuse_high) else $error("high fuse read wrong");

   property p_op_halts;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      op_start |=> core_rsp.stall && (flash_cmd.erase || flash_cmd.write)
         && (op_rem == PROG_CNT_W'(PROG_CYCLES));
   endproperty
   a_op_halts: assert property (p_op_halts) else $error("operation did not halt core");

   property p_op_length;
      @(posedge clk) disable iff (!brownout_reset_n || !ce)
      $past(core_rsp.stall) && !core_rsp.stall |-> ($past(op_rem) == PROG_CNT_W'(1));
   endproperty
   a_op_length: assert property (p_op_length) else $error("operation ended early");

   property p_eeprom_block;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      ctrl_wr_en && eeprom_write_active_flag && (mode_q == MODE_IDLE) |=> (mode_q == MODE_IDLE);
   endproperty
   a_eeprom_block: assert property (p_eeprom_block) else $error("command taken in eeprom write");

   property p_bad_cmd;
      @(posedge clk) disable iff (!reset_n || !brownout_reset_n || !ce)
      ctrl_wr_en && (mode_q == MODE_IDLE) && !cmd_valid && (cmd != CMD_CLEAR_PAGE_BUFFER_BIT)
         && !eeprom_write_active_flag |=> (mode_q == MODE_IDLE) && $stable(buf_valid_q);
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("undefined command acted");

   property p_buf_after_write;
      @(posedge clk) disable iff (!brownout_reset_n || !ce)
      (mode_q == MODE_BUSY_WRITE) && op_expiring |=> (buf_valid_q == '0) && !core_rsp.stall;
   endproperty
   a_buf_after_write: assert property (p_buf_after_write) else $error("buffer kept");

endmodule

`default_nettype wire

// ==== test/core_model.sv ====
// processor core model: store and load instructions toward the block
// assumes one bench process calls its tasks and honours stall
`default_nettype none

module core_model
   import flash_self_program_pkg::*;
(
   // clock
   input wire logic clk,
   // core side
   input wire core_rsp_t rsp,
   output core_req_t req
);
   timeunit 1ns;
   timeprecision 1ns;

   initial req = '0;

   // ==========================================================
   // instructions
   // released lines show a new pattern, never the last value
   task automatic store(input logic [15:0] p, input logic [15:0] d);
      @(posedge clk);
      req <= '{store_program_instruction: 1'b1, load_program_byte_instruction: 1'b0, ptr: p, data_pair: d};
      @(posedge clk);
      req <= '{store_program_instruction: 1'b0, load_program_byte_instruction: 1'b0, ptr: ~p, data_pair: ~d};
   endtask

   // drives the load for one cycle, then waits up to four cycles for load_valid
   task automatic load(input logic [15:0] p, output logic [7:0] q);
      q = 'x;
      @(posedge clk);
      req <= '{store_program_instruction: 1'b0, load_program_byte_instruction: 1'b1, ptr: p, data_pair: 16'h0000};
      @(posedge clk);
      req <= '{store_program_instruction: 1'b0, load_program_byte_instruction: 1'b0, ptr: ~p, data_pair: 16'hFFFF};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         if (rsp.load_valid === 1'b1) begin
            q = rsp.load_data;
            break;
         end
      end
   endtask
endmodule

`default_nettype wire

// ==== test/test_flash_self_program_control.sv ====
// self-checking bench of the flash self-programming control unit
// assumes core_model as the core and a combinational flash read model
`default_nettype none

module test_flash_self_program_control
   import flash_self_program_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // short operation keeps the run brief
   localparam int PC = 20;
   logic clk, reset_n, cyc, stb, we, ack, eeprom_flag;
   logic [31:0] adr, dat_w, dat_o, dat_r;
   logic [4:0] buf_idx;
   logic [7:0] q;
   core_req_t req;
   core_rsp_t rsp;
   nv_bits_t nv;
   flash_rsp_t frsp;
   flash_cmd_t fcmd;
   int n_mismatch, n_compared;
   time t0;

   assign frsp = '{rd_word: {fcmd.rd_word_addr[7:0] ^ 8'h5A, fcmd.rd_word_addr[7:0]},
                   buf_index: buf_idx};

   flash_self_program_control #(.PROG_CYCLES(PC)) dut (.clk(clk), .ce(1'b1),
      .reset_n(reset_n), .brownout_reset_n(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .core_req(req), .core_rsp(rsp), .eeprom_write_active_flag(eeprom_flag),
      .nv_bits(nv), .flash_rsp(frsp), .flash_cmd(fcmd));
   core_model core (.clk(clk), .rsp(rsp), .req(req));

   // ==========================================================
   // helpers
   task automatic end_of_test();
      if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, dat_w} <= {2'b11, w, a, d};
      // no wait limit here: only the watchdog ends a hung request
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      dat_r = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic buf_chk(input logic [4:0] i, input logic [15:0] e);
      @(posedge clk);
      buf_idx <= i;
      @(posedge clk);
      @(negedge clk);
      chk(fcmd.buf_word, e);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_store();
      wb(1, 32'h100, 0);
      chk(dat_r, 0);
      wb(0, PMCS_ADDR, 0);
      chk(dat_r, 0);
      wb(1, PMCS_ADDR, CMD_STORE);
      core.store(16'h0007, 16'h1234);
      buf_chk(3, 16'h1234);
      wb(0, PMCS_ADDR, 0);
      chk(dat_r, 0);
      wb(1, PMCS_ADDR, CMD_STORE);
      repeat (6) @(posedge clk);
      core.store(16'h0008, 16'hBEEF);
      buf_chk(4, 16'hFFFF);
      wb(1, PMCS_ADDR, CMD_CLEAR_PAGE_BUFFER_BIT);
      buf_chk(3, 16'hFFFF);
   endtask
   task automatic t_bad();
      logic [7:0] codes [5] = '{8'h1F, 8'h07, 8'h0B, 8'h02, 8'h10};
      foreach (codes[i]) begin
         wb(1, PMCS_ADDR, {24'h0, codes[i]});
         wb(0, PMCS_ADDR, 0);
         chk(dat_r, 0);
      end
   endtask
   task automatic t_prog(input logic [4:0] code, input logic [15:0] p);
      wb(1, PMCS_ADDR, CMD_STORE);
      core.store(16'h000A, 16'h5555);
      wb(1, PMCS_ADDR, {27'h0, code});
      core.store(p, 16'hA5A5);
      @(negedge clk);
      t0 = $time;
      chk(rsp.stall, 1);
      chk({fcmd.write, fcmd.erase}, {code == CMD_WRITE, code == CMD_ERASE});
      chk(fcmd.page, p[15:6]);
      buf_chk(5, 16'h5555);
      wb(0, PMCS_ADDR, 0);
      chk(dat_r, code);
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4 * PC && rsp.stall === 1'b1; i++) @(negedge clk);
      chk(32'(($time - t0) / 40), PC);
      wb(0, PMCS_ADDR, 0);
      chk(dat_r, 0);
      if (code == CMD_WRITE) buf_chk(5, 16'hFFFF);
   endtask
   task automatic t_fuse();
      logic [15:0] ptrs [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0002};
      logic [7:0] exps [4] = '{8'h7E, 8'hFD, 8'hC3, 8'hFF};
      foreach (ptrs[i]) begin
         wb(1, PMCS_ADDR, CMD_RFL);
         core.load(ptrs[i], q);
         chk(q, exps[i]);
      end
      wb(0, PMCS_ADDR, 0);
      chk(dat_r, 0);
      core.load(16'h0005, q);
      chk(q, 8'h58);
      core.load(16'h0004, q);
      chk(q, 8'h02);
      wb(1, PMCS_ADDR, CMD_RFL);
      repeat (4) @(posedge clk);
      core.load(16'h0000, q);
      chk(q, 8'h00);
   endtask
   task automatic t_eeprom();
      wb(1, PMCS_ADDR, CMD_STORE);
      core.store(16'h000C, 16'h7777);
      eeprom_flag <= 1'b1;
      wb(1, PMCS_ADDR, CMD_WRITE);
      core.store(16'h0040, 16'h0000);
      @(negedge clk);
      chk(rsp.stall, 0);
      wb(1, PMCS_ADDR, CMD_RFL);
      core.load(16'h0000, q);
      chk(q, 8'h00);
      eeprom_flag <= 1'b0;
      buf_chk(6, 16'hFFFF);
   endtask

   // ==========================================================
   // run
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {reset_n, cyc, stb, we, eeprom_flag} = '0;
      {adr, dat_w, buf_idx} = '0;
      nv = '{fuse_low_programmed: 8'h81, fuse_high_programmed: 8'h3C, lock_programmed: 2'b10};
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_store();
      t_bad();
      t_prog(CMD_WRITE, 16'h0AC0);
      t_prog(CMD_ERASE, 16'h1240);
      t_fuse();
      t_eeprom();
      end_of_test();
   end
endmodule

`default_nettype wire
